/* File: rtl/sio_cfg_regs.sv */
// indexed configuration bank 07h..0Ch with key/index/data host access
// assumes host strobes are single-cycle and on the core clock
// Behaviour
// - key, then index, then data window access
// - two type bits per floppy drive
// - drive type chooses reduced write current when the three-mode bit is set
// - two bits choose power-down countdown
// - write block holds write gate/data high
// - soft protect forces write-protect report
// - media id and boot drive bits
// - bit 7 is operating mode top bit
// - lock bit blocks indices zero through B
// - three-mode bit enables tape drive register
// - tape bits 5:4 steer reduced write current
// - chip id nibble read-only
// - portable enable output polarities
// - direction indicator sense select
// - dc sense input polarity
// - extension enable per parallel mode
// - uart clock fast or divided select
// - key value select, strap default
// - uart B infrared select, strap default
// - gpio pin set select, strap default
// - invert uart B receive input
// - invert uart B transmit output
// - index 0B reserved
`timescale 1ns/1ps
module sio_cfg_regs #(
  parameter int TICK_CYCLES = sio_cfg_pkg::TICK_CYCLES,
  parameter logic [3:0] CHIP_ID = 4'hA // arbitrary value
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // host port
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [1:0] i_io_addr,
  input wire logic [7:0] i_io_wdata,
  output logic [7:0] o_io_rdata,
  // strap pins
  input wire logic i_strap_key_sel,
  input wire logic i_strap_infrared_sel,
  input wire logic i_strap_gpio_sel,
  // floppy controller side
  input wire logic [1:0] i_drive_sel,
  input wire logic i_rate_500k,
  input wire logic i_fdc_active,
  input wire logic i_write_gate_n,
  input wire logic i_write_data_out_n,
  input wire logic i_write_protect_n,
  output logic o_reduced_write_current,
  output logic o_write_gate_n,
  output logic o_write_data_out_n,
  output logic o_write_protect_n,
  output logic o_auto_powerdown,
  output logic [1:0] o_media_id,
  output logic [1:0] o_boot_drive,
  output logic o_op_mode_sel_hi,
  // parallel port and portable pins
  input wire logic i_portable_mode,
  input wire logic i_ext_fdc_active,
  input wire logic i_extension_adapter_mode,
  input wire logic i_par_epp,
  input wire logic i_par_ecp,
  input wire logic i_par_ecp_epp,
  input wire logic i_par_data_input,
  input wire logic i_dc_sense_in,
  output logic o_portable_fdc_enable,
  output logic o_portable_ext_enable,
  output logic o_port_dir_indicator,
  output logic o_dc_sense_active,
  // uart B and infrared
  input wire logic i_uart_b_serial_in,
  input wire logic i_uart_b_tx,
  output logic o_uart_b_rx,
  output logic o_ir_transmit_out,
  output logic o_uart_a_fast_clock,
  output logic o_uart_b_fast_clock,
  output logic o_uart_b_infrared_sel,
  output logic o_gpio_function_sel
);
  import sio_cfg_pkg::*;

  // ==========================================================
  // pin synchronisers
  logic [5:0] pin_s;
  sio_sync2 #(.WIDTH(6), .RST_VAL(6'h3F)) u_sync (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_async({i_strap_key_sel, i_strap_infrared_sel, i_strap_gpio_sel,
              i_write_protect_n, i_dc_sense_in, i_uart_b_serial_in}),
    .o_sync(pin_s)
  );
  logic strap_key_s;
  logic strap_ir_s;
  logic strap_gpio_s;
  logic wp_n_s;
  logic dc_s;
  logic rx_s;
  assign {strap_key_s, strap_ir_s, strap_gpio_s, wp_n_s, dc_s, rx_s} = pin_s;

  // ==========================================================
  // registers
  sio_key_state_t key_state_r;
  logic [7:0] index_r;
  logic [7:0] drive_type_r;
  logic [7:0] protect_pd_r;
  logic [7:0] global_mode_r;
  logic [7:0] portable_r;
  logic [7:0] uart_ir_r;
  logic [7:0] tape_drive_reg_r;
  logic [1:0] strap_cnt_r;
  logic strap_done_r;

  // ==========================================================
  // host decode
  logic unlock_key_select;
  logic [7:0] unlock_value;
  logic key_wr;
  logic index_wr;
  logic data_wr;
  logic tape_wr;
  logic is_open;
  logic config_lock;
  logic three_mode_enable;
  logic idx_lockable;
  logic idx_drive_type;
  logic idx_protect_pd;
  logic idx_global_mode;
  logic idx_portable;
  logic idx_uart_ir;
  logic data_ok;

  assign unlock_key_select = uart_ir_r[KEY_SEL_BIT];
  assign unlock_value = unlock_key_select ? KEY_HIGH : KEY_LOW;
  assign is_open = (key_state_r == SIO_OPEN);
  assign config_lock = global_mode_r[LOCK_BIT];
  assign three_mode_enable = global_mode_r[THREE_MODE_BIT];
  assign key_wr = i_io_wr && (i_io_addr == PORT_KEY);
  assign index_wr = i_io_wr && (i_io_addr == PORT_INDEX) && is_open;
  assign data_wr = i_io_wr && (i_io_addr == PORT_DATA) && data_ok;
  assign tape_wr = i_io_wr && (i_io_addr == PORT_TAPE) && three_mode_enable;
  assign idx_lockable = (index_r <= IDX_RESERVED_B);
  assign data_ok = is_open && !(config_lock && idx_lockable);
  assign idx_drive_type = (index_r == IDX_DRIVE_TYPE);
  assign idx_protect_pd = (index_r == IDX_PROTECT_PD);
  assign idx_global_mode = (index_r == IDX_GLOBAL_MODE);
  assign idx_portable = (index_r == IDX_PORTABLE);
  assign idx_uart_ir = (index_r == IDX_UART_IR);

  // ==========================================================
  // key and index
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      key_state_r <= SIO_CLOSED;
    end else if (key_wr) begin
      key_state_r <= (i_io_wdata == unlock_value) ? SIO_OPEN : SIO_CLOSED;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      index_r <= RST_REG;
    end else if (index_wr) begin
      index_r <= i_io_wdata;
    end
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      drive_type_r <= RST_REG;
      protect_pd_r <= RST_REG;
      global_mode_r <= RST_REG;
      portable_r <= RST_REG;
    end else if (data_wr) begin
      if (idx_drive_type) begin
        drive_type_r <= i_io_wdata;
      end
      if (idx_protect_pd) begin
        protect_pd_r <= i_io_wdata;
      end
      if (idx_global_mode) begin
        global_mode_r <= i_io_wdata & MASK_GLOBAL_MODE;
      end
      if (idx_portable) begin
        portable_r <= i_io_wdata;
      end
    end
  end

  // strap levels caught a few cycles after reset release
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      strap_cnt_r <= 2'h0;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
      strap_done_r <= (strap_cnt_r == STRAP_WAIT);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      uart_ir_r <= RST_REG;
      uart_ir_r[KEY_SEL_BIT] <= STRAP_RST;
      uart_ir_r[IR_SEL_BIT] <= STRAP_RST;
      uart_ir_r[GPIO_SEL_BIT] <= STRAP_RST;
    end else if (!strap_done_r) begin
      uart_ir_r[KEY_SEL_BIT] <= strap_key_s;
      uart_ir_r[IR_SEL_BIT] <= strap_ir_s;
      uart_ir_r[GPIO_SEL_BIT] <= strap_gpio_s;
    end else if (data_wr && idx_uart_ir) begin
      uart_ir_r <= i_io_wdata & MASK_UART_IR;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      tape_drive_reg_r <= RST_REG;
    end else if (tape_wr) begin
      tape_drive_reg_r <= i_io_wdata & MASK_TAPE;
    end
  end

  // ==========================================================
  // read path
  logic [7:0] cfg_rd;
  logic [7:0] port_rd;
  assign cfg_rd = !data_ok ? 8'h00 :
                  idx_drive_type ? drive_type_r :
                  idx_protect_pd ? protect_pd_r :
                  idx_global_mode ? {global_mode_r[7:4], CHIP_ID} :
                  idx_portable ? portable_r :
                  idx_uart_ir ? uart_ir_r : 8'h00;
  assign port_rd = (i_io_addr == PORT_KEY) ? 8'h00 :
                   (i_io_addr == PORT_INDEX) ? (is_open ? index_r : 8'h00) :
                   (i_io_addr == PORT_DATA) ? cfg_rd :
                   (three_mode_enable ? tape_drive_reg_r : 8'h00);

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      o_io_rdata <= 8'h00;
    end else if (i_io_rd) begin
      o_io_rdata <= port_rd;
    end
  end

  // ==========================================================
  // reduced write current, one term per drive
  logic [3:0] rwc_drv;
  logic [3:0] drv_normal;
  genvar d;
  generate
    for (d = 0; d < 4; d++) begin : g_drive
      logic [1:0] dtype;
      assign dtype = drive_type_r[2*d+1:2*d];
      assign drv_normal[d] = (dtype == 2'h0) || !three_mode_enable;
      assign rwc_drv[d] = (dtype == 2'h2);
    end
  endgenerate
  logic [1:0] tape_rwc;
  logic rwc_nxt;
  assign tape_rwc = tape_drive_reg_r[TAPE_RWC_LSB+1:TAPE_RWC_LSB];
  assign rwc_nxt = (three_mode_enable && tape_rwc != 2'h0) ?
                   (tape_rwc == 2'h2) :
                   drv_normal[i_drive_sel] ? i_rate_500k :
                   rwc_drv[i_drive_sel];

  // ==========================================================
  // power-down countdown
  logic pd_expired;
  sio_pd_timer #(.TICK_CYCLES(TICK_CYCLES)) u_pd (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_active(i_fdc_active),
    .i_sel(protect_pd_r[PD_SEL_LSB+1:PD_SEL_LSB]),
    .o_expired(pd_expired)
  );

  // ==========================================================
  // output terms
  logic write_block;
  logic ext_mode_hit;
  logic fdc_en_nxt;
  logic ext_en_nxt;
  assign write_block = protect_pd_r[WR_BLOCK_BIT];
  assign ext_mode_hit = |(portable_r[3:0] & {i_extension_adapter_mode, i_par_epp,
                                             i_par_ecp, i_par_ecp_epp});
  assign fdc_en_nxt = !(i_portable_mode && i_ext_fdc_active) ^ portable_r[FDC_POL_BIT];
  assign ext_en_nxt = !(i_portable_mode && ext_mode_hit) ^ portable_r[EXT_POL_BIT];

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      o_reduced_write_current <= 1'b0;
      o_write_gate_n <= 1'b1;
      o_write_data_out_n <= 1'b1;
      o_write_protect_n <= 1'b1;
      o_auto_powerdown <= 1'b0;
      o_media_id <= 2'h0;
      o_boot_drive <= 2'h0;
      o_op_mode_sel_hi <= 1'b0;
    end else begin
      o_reduced_write_current <= rwc_nxt;
      o_write_gate_n <= i_write_gate_n | write_block;
      o_write_data_out_n <= i_write_data_out_n | write_block;
      o_write_protect_n <= wp_n_s & !protect_pd_r[SOFT_WP_BIT];
      o_auto_powerdown <= pd_expired;
      o_media_id <= protect_pd_r[MEDIA_ID_LSB+1:MEDIA_ID_LSB];
      o_boot_drive <= protect_pd_r[BOOT_LSB+1:BOOT_LSB];
      o_op_mode_sel_hi <= global_mode_r[OP_MODE_HI_BIT];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      o_portable_fdc_enable <= 1'b1;
      o_portable_ext_enable <= 1'b1;
      o_port_dir_indicator <= 1'b0;
      o_dc_sense_active <= 1'b0;
    end else begin
      o_portable_fdc_enable <= fdc_en_nxt;
      o_portable_ext_enable <= ext_en_nxt;
      o_port_dir_indicator <= i_par_data_input ^ portable_r[DIR_SENSE_BIT];
      o_dc_sense_active <= dc_s ^ !portable_r[DC_POL_BIT];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      o_uart_b_rx <= 1'b1;
      o_ir_transmit_out <= 1'b1;
      o_uart_a_fast_clock <= 1'b0;
      o_uart_b_fast_clock <= 1'b0;
      o_uart_b_infrared_sel <= STRAP_RST;
      o_gpio_function_sel <= STRAP_RST;
    end else begin
      o_uart_b_rx <= rx_s ^ uart_ir_r[RX_INV_BIT];
      o_ir_transmit_out <= i_uart_b_tx ^ uart_ir_r[TX_INV_BIT];
      o_uart_a_fast_clock <= uart_ir_r[UART_A_FAST_BIT];
      o_uart_b_fast_clock <= uart_ir_r[UART_B_FAST_BIT];
      o_uart_b_infrared_sel <= uart_ir_r[IR_SEL_BIT];
      o_gpio_function_sel <= uart_ir_r[GPIO_SEL_BIT];
    end
  end
endmodule : sio_cfg_regs

/* File: shared/sio_cfg_pkg.sv */
// configuration bank constants: port map, indices, fields, resets, timing
// assumes a 100 MHz core clock and host strobes on that same clock
package sio_cfg_pkg;
  // ==========================================================
  // host port map (two address bits)
  localparam logic [1:0] PORT_KEY = 2'h0;
  localparam logic [1:0] PORT_INDEX = 2'h1;
  localparam logic [1:0] PORT_DATA = 2'h2;
  localparam logic [1:0] PORT_TAPE = 2'h3;
  // ==========================================================
  // unlock key values and register indices
  localparam logic [7:0] KEY_LOW = 8'h88;
  localparam logic [7:0] KEY_HIGH = 8'h89;
  localparam logic [7:0] IDX_DRIVE_TYPE = 8'h07;
  localparam logic [7:0] IDX_PROTECT_PD = 8'h08;
  localparam logic [7:0] IDX_GLOBAL_MODE = 8'h09;
  localparam logic [7:0] IDX_PORTABLE = 8'h0A;
  localparam logic [7:0] IDX_RESERVED_B = 8'h0B;
  localparam logic [7:0] IDX_UART_IR = 8'h0C;
  // ==========================================================
  // field positions
  localparam int PD_SEL_LSB = 6;
  localparam int WR_BLOCK_BIT = 5;
  localparam int SOFT_WP_BIT = 4;
  localparam int MEDIA_ID_LSB = 2;
  localparam int BOOT_LSB = 0;
  localparam int OP_MODE_HI_BIT = 7;
  localparam int LOCK_BIT = 6;
  localparam int THREE_MODE_BIT = 5;
  localparam int FDC_POL_BIT = 7;
  localparam int EXT_POL_BIT = 6;
  localparam int DIR_SENSE_BIT = 5;
  localparam int DC_POL_BIT = 4;
  localparam int UART_A_FAST_BIT = 7;
  localparam int UART_B_FAST_BIT = 6;
  localparam int KEY_SEL_BIT = 5;
  localparam int IR_SEL_BIT = 3;
  localparam int GPIO_SEL_BIT = 2;
  localparam int RX_INV_BIT = 1;
  localparam int TX_INV_BIT = 0;
  localparam int TAPE_RWC_LSB = 4;
  // writable bit masks; masked-out bits read zero, except 09h bits 3:0, which read the chip id
  localparam logic [7:0] MASK_GLOBAL_MODE = 8'hE0;
  localparam logic [7:0] MASK_UART_IR = 8'hEF;
  localparam logic [7:0] MASK_TAPE = 8'h30;
  // ==========================================================
  // reset values
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic STRAP_RST = 1'b1;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  // ==========================================================
  // power-down timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int PD_SEL0_S = 4;
  localparam int PD_SEL1_S = 32;
  localparam int PD_SEL2_S = 64;
  localparam int PD_SEL3_MIN = 4;
  localparam int TICKS_PER_S = 1000;
  localparam logic [17:0] PD_TICKS0 = 18'(PD_SEL0_S * TICKS_PER_S);
  localparam logic [17:0] PD_TICKS1 = 18'(PD_SEL1_S * TICKS_PER_S);
  localparam logic [17:0] PD_TICKS2 = 18'(PD_SEL2_S * TICKS_PER_S);
  localparam logic [17:0] PD_TICKS3 = 18'(PD_SEL3_MIN * 60 * TICKS_PER_S);
  // ==========================================================
  typedef enum logic [0:0] {
    SIO_CLOSED = 1'b0,
    SIO_OPEN = 1'b1
  } sio_key_state_t;
endpackage : sio_cfg_pkg

/* File: rtl/sio_sync2.sv */
// two-flop synchroniser, one flop pair per bit
// assumes inputs arrive from pins outside the core clock domain
`timescale 1ns/1ps
module sio_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // data
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_r;
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
          meta_r[g] <= RST_VAL[g];
          o_sync[g] <= RST_VAL[g];
        end else begin
          meta_r[g] <= i_async[g];
          o_sync[g] <= meta_r[g];
        end
      end
    end
  endgenerate
endmodule : sio_sync2

/* File: rtl/sio_pd_timer.sv */
// automatic power-down countdown, millisecond tick from a divider
// assumes i_active pulses or holds while the floppy side is busy
`timescale 1ns/1ps
module sio_pd_timer #(
  parameter int TICK_CYCLES = 100000
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // control
  input wire logic i_active,
  input wire logic [1:0] i_sel,
  output logic o_expired
);
  import sio_cfg_pkg::*;
  localparam int PW = $clog2(TICK_CYCLES + 1);
  logic [PW-1:0] pre_r;
  logic [17:0] ms_r;
  logic [17:0] limit;
  logic tick;
  assign tick = (pre_r == PW'(TICK_CYCLES - 1));
  assign limit = (i_sel == 2'h0) ? PD_TICKS0 :
                 (i_sel == 2'h1) ? PD_TICKS1 :
                 (i_sel == 2'h2) ? PD_TICKS2 : PD_TICKS3;
  always_ff @(posedge i_mclk) begin
    if (!i_rstn || i_active) begin
      pre_r <= '0;
      ms_r <= '0;
      o_expired <= 1'b0;
    end else begin
      pre_r <= tick ? '0 : pre_r + 1'b1;
      if (tick && ms_r < limit) begin
        ms_r <= ms_r + 18'h00001;
      end
      o_expired <= (ms_r >= limit);
    end
  end
endmodule : sio_pd_timer

/* File: bench/sio_host_model.sv */
// host bus master model for the configuration bank
// assumes strobes are sampled on the rising clock edge
`timescale 1ns/1ps
module sio_host_model (
  // clock
  input wire logic i_mclk,
  // host bus
  output logic o_wr,
  output logic o_rd,
  output logic [1:0] o_addr,
  output logic [7:0] o_wdata,
  input wire logic [7:0] i_rdata
);
  import sio_cfg_pkg::*;
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 2'h0;
    o_wdata = 8'h00;
  end
  // ====
  // one-cycle strobe, then data driven to its inverse
  task automatic cyc(input logic w, input logic [1:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    o_wr = w;
    o_rd = !w;
    o_addr = a;
    o_wdata = d;
    @(negedge i_mclk);
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = ~d;
  endtask : cyc
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    cyc(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    cyc(1'b0, a, 8'h00);
    @(negedge i_mclk);
    d = i_rdata;
  endtask : rd
  // index first, then data window
  task automatic setreg(input logic [7:0] i, input logic [7:0] d);
    wr(PORT_INDEX, i);
    wr(PORT_DATA, d);
  endtask : setreg
  task automatic getreg(input logic [7:0] i, output logic [7:0] d);
    wr(PORT_INDEX, i);
    rd(PORT_DATA, d);
  endtask : getreg
endmodule : sio_host_model

/* File: bench/sio_cfg_regs_sva.sv */
// port checker for the configuration bank
// assumes bind onto sio_cfg_regs, one clock domain
`timescale 1ns/1ps
module sio_cfg_regs_sva
  import sio_cfg_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // watched ports
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [1:0] i_io_addr,
  input wire logic [7:0] o_io_rdata,
  input wire logic i_write_gate_n,
  input wire logic o_write_gate_n,
  input wire logic i_write_data_out_n,
  input wire logic o_write_data_out_n,
  input wire logic i_write_protect_n,
  input wire logic o_write_protect_n,
  input wire logic i_uart_b_tx,
  input wire logic o_ir_transmit_out,
  input wire logic i_par_data_input,
  input wire logic o_port_dir_indicator,
  input wire logic i_fdc_active,
  input wire logic o_auto_powerdown
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rstn);
  AST_RST_VAL: assert property ($rose(i_rstn) |-> o_io_rdata == 8'h00 && o_ir_transmit_out)
    else $error("outputs not at reset level");
  AST_KEY_RD: assert property (i_io_rd && i_io_addr == PORT_KEY |=> o_io_rdata == 8'h00)
    else $error("key port read not zero");
  AST_RD_HOLD: assert property (!i_io_rd |=> $stable(o_io_rdata))
    else $error("read data moved without a read");
  AST_RD_SRC: assert property ($changed(o_io_rdata) |-> $past(i_io_rd))
    else $error("read data changed with no read before");
  AST_WG_IDLE: assert property (i_write_gate_n |=> o_write_gate_n)
    else $error("write gate active while idle at input");
  AST_WD_ACT: assert property (!o_write_data_out_n |-> $past(i_write_data_out_n) == 1'b0)
    else $error("write data active without a cause");
  AST_WP_PIN: assert property (!i_write_protect_n [*4] |-> !o_write_protect_n)
    else $error("write protect pin not passed");
  AST_TX_FOLLOW: assert property ($past(i_rstn) && !i_io_wr && !$past(i_io_wr)
      && $changed(i_uart_b_tx) |=> $changed(o_ir_transmit_out))
    else $error("transmit output did not follow");
  AST_DIR_FOLLOW: assert property ($past(i_rstn) && !i_io_wr && !$past(i_io_wr)
      && $changed(i_par_data_input) |=> $changed(o_port_dir_indicator))
    else $error("direction indicator did not follow");
  AST_PD_CLR: assert property (i_fdc_active [*2] |=> !o_auto_powerdown)
    else $error("power-down flag held during activity");
  AST_PD_LOW: assert property ($rose(o_auto_powerdown) |-> $past(i_fdc_active, 8) == 1'b0)
    else $error("power-down flag rose too soon");
endmodule : sio_cfg_regs_sva
bind sio_cfg_regs sio_cfg_regs_sva sio_cfg_regs_sva_inst (.*);

/* File: bench/sio_cfg_regs_tb.sv */
// self-checking bench for the configuration bank
// assumes the host model and the checker bind are compiled first
`timescale 1ns/1ps
module sio_cfg_regs_tb;
  import sio_cfg_pkg::*;
  localparam int TICKS = 4;
  localparam logic [3:0] CID = 4'h5; // arbitrary value
  logic i_mclk, i_rstn, i_io_wr, i_io_rd;
  logic [1:0] i_io_addr, i_drive_sel, o_media_id, o_boot_drive;
  logic [7:0] i_io_wdata, o_io_rdata;
  logic i_rate_500k, i_fdc_active, i_write_gate_n, i_write_data_out_n, i_write_protect_n;
  logic i_portable_mode, i_extension_adapter_mode, i_par_epp, i_par_ecp, i_par_ecp_epp;
  logic i_par_data_input, i_dc_sense_in, i_uart_b_serial_in, i_uart_b_tx;
  logic i_ext_fdc_active, i_strap_key_sel, i_strap_infrared_sel, i_strap_gpio_sel;
  logic o_reduced_write_current, o_write_gate_n, o_write_data_out_n, o_write_protect_n;
  logic o_auto_powerdown, o_op_mode_sel_hi, o_portable_fdc_enable, o_portable_ext_enable;
  logic o_port_dir_indicator, o_dc_sense_active, o_uart_b_rx, o_ir_transmit_out;
  logic o_uart_a_fast_clock, o_uart_b_fast_clock, o_uart_b_infrared_sel, o_gpio_function_sel;
  int n_mismatch = 0;
  int n_checks = 0;
  sio_cfg_regs #(.TICK_CYCLES(TICKS), .CHIP_ID(CID)) sio_cfg_regs_inst (
    .*
  );
  sio_host_model sio_host_model_inst (
    .i_mclk(i_mclk),
    .o_wr(i_io_wr),
    .o_rd(i_io_rd),
    .o_addr(i_io_addr),
    .o_wdata(i_io_wdata),
    .i_rdata(o_io_rdata)
  );
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  // ====
  // helpers
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic st();
    repeat (4) @(negedge i_mclk);
  endtask : st
  task automatic sr(input logic [7:0] i, input logic [7:0] d);
    sio_host_model_inst.setreg(i, d);
  endtask : sr
  task automatic rchk(input string nm, input logic [7:0] i, input logic [7:0] e);
    logic [7:0] v;
    sio_host_model_inst.getreg(i, v);
    chk(nm, e, v);
  endtask : rchk
  task automatic pchk(input string nm, input logic [1:0] a, input logic [7:0] e);
    logic [7:0] v;
    sio_host_model_inst.rd(a, v);
    chk(nm, e, v);
  endtask : pchk
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict
  // ====
  // scenarios
  task automatic t_access();
    rchk("closed", IDX_UART_IR, 8'h00);
    pchk("key port", PORT_KEY, 8'h00);
    sio_host_model_inst.wr(PORT_KEY, KEY_HIGH);
    rchk("strap 0C", IDX_UART_IR, 8'h2C);
    rchk("chip id", IDX_GLOBAL_MODE, {4'h0, CID});
    sr(IDX_GLOBAL_MODE, 8'hBF);
    rchk("mode 09", IDX_GLOBAL_MODE, {4'hA, CID});
    chk("op mode hi", 8'h01, 8'(o_op_mode_sel_hi));
  endtask : t_access
  task automatic t_rwc();
    logic [3:0] exp_t;
    exp_t = 4'b0101;
    sr(IDX_DRIVE_TYPE, 8'hE4);
    rchk("types", IDX_DRIVE_TYPE, 8'hE4);
    for (int d = 0; d < 4; d++) begin
      i_drive_sel = 2'(d);
      st();
      chk("rwc type", 8'(exp_t[d]), 8'(o_reduced_write_current));
    end
    sio_host_model_inst.wr(PORT_TAPE, 8'hFF);
    pchk("tape", PORT_TAPE, 8'h30);
    i_drive_sel = 2'h2;
    st();
    chk("rwc tape 11", 8'h00, 8'(o_reduced_write_current));
    sio_host_model_inst.wr(PORT_TAPE, 8'h20);
    i_drive_sel = 2'h1;
    st();
    chk("rwc tape 10", 8'h01, 8'(o_reduced_write_current));
    sr(IDX_GLOBAL_MODE, 8'h80);
    sio_host_model_inst.wr(PORT_TAPE, 8'h10);
    pchk("tape off", PORT_TAPE, 8'h00);
    i_rate_500k = 1'b0;
    st();
    chk("rwc normal", 8'h00, 8'(o_reduced_write_current));
  endtask : t_rwc
  task automatic t_protect();
    sr(IDX_PROTECT_PD, 8'h3E);
    st();
    chk("blocked", 8'h06, {5'h0, o_write_gate_n, o_write_data_out_n, o_write_protect_n});
    chk("media boot", 8'h0E, {4'h0, o_media_id, o_boot_drive});
    sr(IDX_PROTECT_PD, 8'h00);
    st();
    chk("passed", 8'h01, {5'h0, o_write_gate_n, o_write_data_out_n, o_write_protect_n});
    i_write_protect_n = 1'b0;
    st();
    chk("wp pin", 8'h00, 8'(o_write_protect_n));
  endtask : t_protect
  task automatic t_portable();
    sr(IDX_PORTABLE, 8'h68);
    {i_portable_mode, i_extension_adapter_mode, i_par_data_input, i_dc_sense_in} = 4'hE;
    i_ext_fdc_active = 1'b1;
    st();
    chk("portable", 8'h05, {4'h0, o_portable_fdc_enable, o_portable_ext_enable,
      o_port_dir_indicator, o_dc_sense_active});
    {i_extension_adapter_mode, i_par_epp, i_par_data_input} = 3'h2;
    st();
    chk("portable epp", 8'h03, {4'h0, o_portable_fdc_enable, o_portable_ext_enable,
      o_port_dir_indicator, o_dc_sense_active});
  endtask : t_portable
  task automatic t_uart();
    sr(IDX_UART_IR, 8'hD3);
    rchk("0C", IDX_UART_IR, 8'hC3);
    {i_uart_b_serial_in, i_uart_b_tx} = 2'h3;
    st();
    chk("uart", 8'h30, {2'h0, o_uart_a_fast_clock, o_uart_b_fast_clock, o_uart_b_infrared_sel,
      o_gpio_function_sel, o_uart_b_rx, o_ir_transmit_out});
    sio_host_model_inst.wr(PORT_KEY, KEY_HIGH);
    rchk("old key", IDX_UART_IR, 8'h00);
    sio_host_model_inst.wr(PORT_KEY, KEY_LOW);
    rchk("new key", IDX_UART_IR, 8'hC3);
    sr(IDX_RESERVED_B, 8'hFF);
    rchk("0B", IDX_RESERVED_B, 8'h00);
  endtask : t_uart
  task automatic t_lock();
    sr(IDX_GLOBAL_MODE, 8'hE0);
    sio_host_model_inst.wr(PORT_TAPE, 8'h00);
    sr(IDX_DRIVE_TYPE, 8'hAA);
    i_drive_sel = 2'h1;
    st();
    chk("locked rwc", 8'h00, 8'(o_reduced_write_current));
    rchk("locked rd", IDX_DRIVE_TYPE, 8'h00);
  endtask : t_lock
  task automatic t_pd();
    int k;
    i_fdc_active = 1'b0;
    i_write_gate_n = 1'b1;
    repeat (15980) @(negedge i_mclk);
    chk("pd early", 8'h00, 8'(o_auto_powerdown));
    for (k = 0; k < 60 && o_auto_powerdown !== 1'b1; k++) @(negedge i_mclk);
    chk("pd due", 8'h01, 8'(o_auto_powerdown));
    if (k == 60) begin
      print_verdict();
    end
    i_fdc_active = 1'b1;
    st();
    chk("pd clear", 8'h00, 8'(o_auto_powerdown));
  endtask : t_pd
  task automatic t_strap();
    {i_strap_key_sel, i_strap_infrared_sel, i_strap_gpio_sel} = 3'h0;
    i_rstn = 1'b0;
    repeat (5) @(negedge i_mclk);
    i_rstn = 1'b1;
    repeat (6) @(negedge i_mclk);
    sio_host_model_inst.wr(PORT_KEY, KEY_LOW);
    rchk("strap key", IDX_GLOBAL_MODE, {4'h0, CID});
    rchk("strap 0C", IDX_UART_IR, 8'h00);
    chk("strap pins", 8'h00, {6'h0, o_uart_b_infrared_sel, o_gpio_function_sel});
  endtask : t_strap
  // ====
  // main sequence
  initial begin
    {i_rstn, i_fdc_active, i_rate_500k, i_write_protect_n, i_dc_sense_in} = 5'h0F;
    {i_drive_sel, i_write_gate_n, i_write_data_out_n, i_portable_mode} = '0;
    {i_extension_adapter_mode, i_par_epp, i_par_ecp, i_par_ecp_epp} = '0;
    {i_par_data_input, i_uart_b_serial_in, i_uart_b_tx} = '0;
    {i_ext_fdc_active, i_strap_key_sel, i_strap_infrared_sel, i_strap_gpio_sel} = 4'h7;
    repeat (5) @(negedge i_mclk);
    i_rstn = 1'b1;
    repeat (6) @(negedge i_mclk);
    t_access();
    t_rwc();
    t_protect();
    t_portable();
    t_uart();
    t_lock();
    t_pd();
    t_strap();
    print_verdict();
  end
endmodule : sio_cfg_regs_tb
